// ==== logic/mux_adc_seq_defines.svh ====
`ifndef MUX_ADC_SEQ_DEFINES_SVH
`define MUX_ADC_SEQ_DEFINES_SVH

// Register indices as printed; byte address is four times the index
`define STEP13_CFG_INDEX 8'hdd
`define STEP14_CFG_INDEX 8'hde
`define STEP13_CFG_ADDR 10'h374
`define STEP14_CFG_ADDR 10'h378
`define STEP13_CFG_RESET 16'h000d
`define STEP14_CFG_RESET 16'h000e
`define STEP_ENABLE_BIT 15
`define STEP_GAIN_MSB 14
`define STEP_GAIN_LSB 13
`define STEP_NEG_BIT 4
`define STEP_POS_MSB 3
`define STEP_POS_LSB 0
`define STEP_WRITE_MASK 16'he01f
`define POS_AUTO_NEG_MIN 4'h8

`endif

// ==== logic/mux_adc_seq_pkg.sv ====
package mux_adc_seq_pkg;
   typedef enum logic [1:0] {
      GAIN_X1 = 2'b00,
      GAIN_X2 = 2'b01,
      GAIN_X4 = 2'b10
   } gain_t;

   typedef enum logic [3:0] {
      POS_EXT0 = 4'b0000, POS_EXT1 = 4'b0001, POS_EXT2 = 4'b0010, POS_EXT3 = 4'b0011,
      POS_EXT4 = 4'b0100, POS_EXT5 = 4'b0101, POS_EXT6 = 4'b0110, POS_EXT7 = 4'b0111,
      POS_TEMP = 4'b1000, POS_SHORT = 4'b1001, POS_TEST_DAC = 4'b1010,
      POS_RSVD = 4'b1011, POS_IO_DIV4 = 4'b1100, POS_DIG_DIV2 = 4'b1101,
      POS_ANALOG_POWER_RAIL_DIV103 = 4'b1110, POS_DIGITAL_POWER_RAIL_DIV103 = 4'b1111
   } pos_sel_t;

   typedef enum logic [1:0] {
      NEG_GROUND = 2'b00,
      NEG_EXT7 = 2'b01,
      NEG_AUTO = 2'b10
   } neg_sel_t;

   // Decoded settings that the sequencer applies for one step
   typedef struct packed {
      logic active;
      gain_t gain;
      neg_sel_t neg;
      pos_sel_t pos;
   } step_route_t;
endpackage

// ==== logic/mux_adc_seq_step_cfg.sv ====
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "mux_adc_seq_defines.svh"
// What this block does
// [RL1] Bit 15 enables sequence step 13 when 1 and disables it when 0, read/write, reset 0.
// [RL2] Bits 14:13 select gain 1 for 00, 2 for 01 and 4 for 10 or 11, reset 00.
// [RL3] Bits 12:5 are reserved, read-only and always read zero.
// [RL4] Bit 4 selects ground reference at 0 or external input 7 at 1, read/write, reset 0.
// [RL5] Bits 3:0 codes 0000 to 0111 route external input n to the positive input, reset 1101.
// [RL6] Codes 1000, 1001 and 1010 pick temperature sensor, internal short and test DAC.
// [RL7] Codes 1100 to 1111 pick the supply monitor taps; every code from 1000 to 1111 uses automatic negative input.
// [RL8] For codes with automatic negative input the negative-select bit is ignored.
// [RL9] The step-14 register sits at index DEh and resets to 000Eh.
// [RL10] The step-13 register sits at index DDh and resets to 000Dh.
// [RL11] A disabled step is skipped and runs no conversion with its settings.
module mux_adc_seq_step_cfg
   import mux_adc_seq_pkg::*;
(
   input wire logic REF_CLK_I, // 50 MHz core clock
   input wire logic RST_B_I, // Async reset, active low
   input wire logic WB_CYC_I, // Wishbone cycle
   input wire logic WB_STB_I, // Wishbone strobe
   input wire logic WB_WE_I, // Wishbone write enable
   input wire logic [9:0] WB_ADR_I, // Wishbone byte address
   input wire logic [3:0] WB_SEL_I, // Wishbone byte selects
   input wire logic [31:0] WB_DAT_I, // Wishbone write data
   output logic [31:0] WB_DAT_O, // Wishbone read data
   output logic WB_ACK_O, // Wishbone acknowledge
   output logic WB_ERR_O, // Wishbone error, unmapped address
   output step_route_t STEP13_ROUTE_O, // Decoded step 13 settings
   output step_route_t STEP14_ROUTE_O // Decoded step 14 settings
);

   logic [15:0] step13_q, step13_d;
   logic [15:0] step14_q, step14_d;
   logic [31:0] rdata_q, rdata_d;
   logic ack_q, ack_d;
   logic err_q, err_d;
   step_route_t route13_q, route13_d;
   step_route_t route14_q, route14_d;
   logic req;
   logic hit13;
   logic hit14;
   logic [15:0] wmask;

   function automatic step_route_t decode_step(input logic [15:0] cfg);
      step_route_t r;
      logic [3:0] pos;
      pos = cfg[`STEP_POS_MSB:`STEP_POS_LSB];
      r.active = cfg[`STEP_ENABLE_BIT]; // RL1 RL11
      case (cfg[`STEP_GAIN_MSB:`STEP_GAIN_LSB]) // RL2
         2'b00: r.gain = GAIN_X1;
         2'b01: r.gain = GAIN_X2;
         default: r.gain = GAIN_X4;
      endcase
      r.pos = pos_sel_t'(pos); // RL5 RL6 RL7
      if (pos >= `POS_AUTO_NEG_MIN) begin
         r.neg = NEG_AUTO; // RL8
      end else if (cfg[`STEP_NEG_BIT]) begin
         r.neg = NEG_EXT7; // RL4
      end else begin
         r.neg = NEG_GROUND;
      end
      // Disabled step: clear the routing so no conversion uses stale settings
      if (!r.active) begin
         r.gain = GAIN_X1; // RL11
         r.neg = NEG_GROUND;
         r.pos = POS_EXT0;
      end
      return r;
   endfunction

   assign req = WB_CYC_I & WB_STB_I & ~ack_q & ~err_q;
   assign hit13 = (WB_ADR_I == `STEP13_CFG_ADDR); // RL10
   assign hit14 = (WB_ADR_I == `STEP14_CFG_ADDR); // RL9
   // Only the two low byte lanes carry the 16-bit registers
   assign wmask = {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}} & `STEP_WRITE_MASK; // RL3

   always_comb begin
      step13_d = step13_q;
      step14_d = step14_q;
      rdata_d = rdata_q;
      ack_d = 1'b0;
      err_d = 1'b0;
      if (req) begin
         if (hit13 || hit14) begin
            ack_d = 1'b1;
         end else begin
            err_d = 1'b1;
         end
         if (WB_WE_I && hit13) begin
            step13_d = (step13_q & ~wmask) | (WB_DAT_I[15:0] & wmask);
         end
         if (WB_WE_I && hit14) begin
            step14_d = (step14_q & ~wmask) | (WB_DAT_I[15:0] & wmask);
         end
         if (hit13) begin
            rdata_d = {16'h0000, step13_q & `STEP_WRITE_MASK}; // RL3
         end else if (hit14) begin
            rdata_d = {16'h0000, step14_q & `STEP_WRITE_MASK};
         end else begin
            rdata_d = 32'h0000_0000;
         end
      end
      route13_d = decode_step(step13_d);
      route14_d = decode_step(step14_d);
   end

   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         step13_q <= `STEP13_CFG_RESET; // RL10
         step14_q <= `STEP14_CFG_RESET; // RL9
         rdata_q <= 32'h0000_0000;
         ack_q <= 1'b0;
         err_q <= 1'b0;
         route13_q <= '{active: 1'b0, gain: GAIN_X1, neg: NEG_GROUND, pos: POS_EXT0};
         route14_q <= '{active: 1'b0, gain: GAIN_X1, neg: NEG_GROUND, pos: POS_EXT0};
      end else begin
         step13_q <= step13_d;
         step14_q <= step14_d;
         rdata_q <= rdata_d;
         ack_q <= ack_d;
         err_q <= err_d;
         route13_q <= route13_d;
         route14_q <= route14_d;
      end
   end

   assign WB_DAT_O = rdata_q;
   assign WB_ACK_O = ack_q;
   assign WB_ERR_O = err_q;
   assign STEP13_ROUTE_O = route13_q;
   assign STEP14_ROUTE_O = route14_q;

endmodule

// ==== testbench/mux_adc_seq_step_cfg_assertions.sv ====
`timescale 1ns/1ps
module mux_adc_seq_step_cfg_chk
   import mux_adc_seq_pkg::*;
(
   input wire logic REF_CLK_I, // Clock
   input wire logic RST_B_I, // Reset
   input wire logic WB_CYC_I, // Cycle
   input wire logic WB_STB_I, // Strobe
   input wire logic WB_WE_I, // Write
   input wire logic [9:0] WB_ADR_I, // Address
   input wire logic [3:0] WB_SEL_I, // Lanes
   input wire logic [31:0] WB_DAT_I, // Write data
   input wire logic [31:0] WB_DAT_O, // Read data
   input wire logic WB_ACK_O, // Ack
   input wire logic WB_ERR_O, // Error
   input wire step_route_t STEP13_ROUTE_O // Step 13 route
);
   wire tk = WB_CYC_I & WB_STB_I & ~WB_ACK_O & ~WB_ERR_O;
   wire on = STEP13_ROUTE_O.active;
   wire p3 = STEP13_ROUTE_O.pos[3];
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_B_I);
   a_rsvd_zero: assert property (WB_ACK_O |-> WB_DAT_O[12:5] == 8'h00) else $error("rsvd");
   a_off_blank: assert property (!on |-> STEP13_ROUTE_O == '0) else $error("blank");
   a_gain_code: assert property (STEP13_ROUTE_O.gain != 2'b11) else $error("gain");
   a_auto_neg: assert property (on && p3 |-> STEP13_ROUTE_O.neg == NEG_AUTO) else $error("auto");
   a_ext_neg: assert property (on && !p3 |-> STEP13_ROUTE_O.neg != NEG_AUTO) else $error("neg");
   a_ack_thirteen: assert property (tk && WB_ADR_I == 10'h374 |=> WB_ACK_O) else $error("ack13");
   a_ack_fourteen: assert property (tk && WB_ADR_I == 10'h378 |=> WB_ACK_O) else $error("ack14");
   a_en_follow:
      assert property (tk && WB_WE_I && WB_SEL_I[1] && WB_ADR_I == 10'h374 |=>
         on == $past(WB_DAT_I[15])) else $error("enable");
endmodule
bind mux_adc_seq_step_cfg mux_adc_seq_step_cfg_chk u_chk (.*);

// ==== testbench/tb_mux_adc_seq_step_cfg.sv ====
`timescale 1ns/1ps
module tb_mux_adc_seq_step_cfg;
   import mux_adc_seq_pkg::*;
   logic clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, ack, err;
   logic [9:0] adr = '0;
   logic [3:0] sel = '0;
   logic [3:0] ls = 4'h3;
   logic [31:0] dat = '0, dout;
   logic [32:0] q;
   logic [15:0] v, m;
   step_route_t r13, r14;
   int fails = 0, comparisons = 0, ticks = 0;
   always #10 clk = ~clk;
   mux_adc_seq_step_cfg u_dut (.REF_CLK_I(clk), .RST_B_I(rst_b), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
      .WB_DAT_O(dout), .WB_ACK_O(ack), .WB_ERR_O(err), .STEP13_ROUTE_O(r13),
      .STEP14_ROUTE_O(r14));
   task automatic close_out;
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [32:0] g, input logic [32:0] e);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("mismatch t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // Old ack value is seen at the edge, so the answer is taken where it was sampled
   task automatic wb(input logic w, input logic [9:0] a, input logic [15:0] d);
      @(posedge clk);
      {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, ls, 16'h0, d};
      @(posedge clk);
      while (ack !== 1'b1 && err !== 1'b1) @(posedge clk);
      q = {err, dout};
      {cyc, stb} <= 2'b00;
   endtask
   // Codes 10 and 11 both mean gain 4; upper positive codes force automatic negative
   function automatic logic [32:0] rt(input logic [15:0] x);
      rt = x[15] ? {x[15], x[14] ? 2'b10 : {1'b0, x[13]}, x[3] ? 2'b10 : {1'b0, x[4]}, x[3:0]} : 0;
   endfunction
   always @(posedge clk) begin
      ticks++;
      if (ticks == 3000) begin
         fails++;
         close_out;
      end
   end
   initial begin
      void'($urandom(41251));
      repeat (12) @(posedge clk);
      rst_b <= 1;
      wb(0, 10'h374, 0);
      chk(q, 33'h0000d);
      wb(0, 10'h378, 0);
      chk(q, 33'h0000e);
      chk(r13, 33'h0);
      for (int i = 0; i < 64; i++) begin
         v = 16'($urandom);
         {v[14:13], v[3:0]} = i[5:0];
         m = v & 16'he01f;
         wb(1, 10'h374, v);
         chk(r13, rt(m));
         wb(0, 10'h374, 0);
         chk(q, {17'h0, m});
         wb(1, 10'h378, ~v);
         chk(r14, rt(~v));
      end
      wb(1, 10'h37c, 16'hffff);
      chk(q, {1'b1, 32'h0});
      wb(0, 10'h374, 0);
      chk(q, {17'h0, m});
      // Only lane 0 selected: the upper byte must keep its old contents
      ls = 4'h1;
      wb(1, 10'h374, 16'hffff);
      ls = 4'h3;
      wb(0, 10'h374, 0);
      chk(q, {17'h0, (m & 16'he000) | 16'h001f});
      close_out;
   end
endmodule
